// ==== core/fpc_pkg.sv ====
package fpc_pkg;

  // ----------------------------------------------------------------
  // Number format
  // ----------------------------------------------------------------
  localparam int EXP_BITS = 8;
  localparam int FRAC_BITS = 23;
  localparam int EXP_BIAS = 127;
  localparam int EXP_MIN = -126;
  localparam int EXP_MAX = 127;
  localparam int TEXP_BITS = 10;
  localparam logic [31:0] QNAN_INDEFINITE = 32'hFFC0_0000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPA = 8'h04;
  localparam logic [7:0] ADDR_OPB = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0C;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_FLAGS = 8'h18;

  // Control register fields.
  localparam int CTRL_VECTOR_BIT = 0;
  localparam int CTRL_MASK_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // Command register fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_UNARY_BIT = 2;
  localparam int CMD_INVALID_BIT = 3;
  localparam int CMD_SIGN_BIT = 4;
  localparam int CMD_TEXP_LSB = 16;

  // Status register fields.
  localparam int STAT_CLASS_A_LSB = 0;
  localparam int STAT_CLASS_B_LSB = 4;
  localparam int STAT_CMP_LSB = 8;
  localparam int STAT_WRITTEN_BIT = 12;
  localparam int STAT_DONE_BIT = 13;

  // Sticky flag bits, write one to clear.
  localparam int FLAG_INVALID = 0;
  localparam int FLAG_DENORM = 1;
  localparam int FLAG_UNDERFLOW = 2;
  localparam int FLAG_TRAP = 3;
  localparam int FLAG_COUNT = 4;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {OP_SELECT, OP_COMPARE, OP_PACK} fpc_op_e;
  typedef enum logic [2:0] {CL_ZERO, CL_DENORM, CL_NORMAL, CL_INF, CL_QNAN, CL_SNAN} fpc_class_e;
  typedef enum logic [1:0] {CMP_EQ, CMP_LT, CMP_GT, CMP_UN} fpc_cmp_e;

endpackage

// ==== core/fpc_classify_nan.sv ====
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
module fpc_classify_nan #(
  parameter int EXP_W = fpc_pkg::EXP_BITS,
  parameter int FRAC_W = fpc_pkg::FRAC_BITS
) (
  input wire logic aclk, // Core clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic [2:0] s_axi_awprot, // Write protection, unused.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic [2:0] s_axi_arprot, // Read protection, unused.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic result_valid, // One-cycle pulse when a command completes.
  output logic invalid_trap // One-cycle pulse on an unmasked invalid operation.
);

  localparam int W = 1 + EXP_W + FRAC_W;
  localparam int SW = FRAC_W + 1;
  localparam int XW = fpc_pkg::TEXP_BITS;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic fpc_pkg::fpc_class_e classify(input logic [W-1:0] v);
    logic [EXP_W-1:0] e;
    logic [FRAC_W-1:0] f;
    e = v[W-2 -: EXP_W];
    f = v[FRAC_W-1:0];
    if (&e) begin
      if (f == '0) begin
        classify = fpc_pkg::CL_INF;
      end else if (f[FRAC_W-1]) begin
        classify = fpc_pkg::CL_QNAN;
      end else begin
        classify = fpc_pkg::CL_SNAN;
      end
    end else if (e == '0) begin
      classify = (f == '0) ? fpc_pkg::CL_ZERO : fpc_pkg::CL_DENORM;
    end else begin
      classify = fpc_pkg::CL_NORMAL;
    end
  endfunction

  function automatic logic [W-1:0] quiet(input logic [W-1:0] v);
    quiet = v;
    quiet[FRAC_W-1] = 1'b1;
  endfunction

  function automatic logic is_nan(input fpc_pkg::fpc_class_e c);
    is_nan = (c == fpc_pkg::CL_QNAN) || (c == fpc_pkg::CL_SNAN);
  endfunction

  // Maps a non-NaN encoding onto an unsigned key whose order is numeric order.
  function automatic logic [W-1:0] order_key(input logic [W-1:0] v);
    order_key = v[W-1] ? ~v : {1'b1, v[W-2:0]};
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic ctrl_vector;
  logic ctrl_mask;
  logic [W-1:0] opa;
  logic [W-1:0] opb;
  logic [31:0] cmd;
  logic go;
  logic [W-1:0] result;
  logic [2:0] class_a;
  logic [2:0] class_b;
  logic [1:0] cmp_code;
  logic written;
  logic done;
  logic [fpc_pkg::FLAG_COUNT-1:0] flags;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;

  wire aw_take = s_axi_awvalid && !aw_full;
  wire w_take = s_axi_wvalid && !w_full;
  wire do_write = aw_full && w_full && !bvalid;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire wr_ctrl = do_write && (aw_addr == fpc_pkg::ADDR_CTRL);
  wire wr_opa = do_write && (aw_addr == fpc_pkg::ADDR_OPA);
  wire wr_opb = do_write && (aw_addr == fpc_pkg::ADDR_OPB);
  wire wr_cmd = do_write && (aw_addr == fpc_pkg::ADDR_CMD);
  wire wr_flags = do_write && (aw_addr == fpc_pkg::ADDR_FLAGS);
  wire wr_mapped = wr_ctrl || wr_opa || wr_opb || wr_cmd || wr_flags;
  wire [31:0] ctrl_word = {30'h0, ctrl_mask, ctrl_vector};
  wire [31:0] ctrl_new = (ctrl_word & ~wmask) | (w_data & wmask);
  wire [31:0] opa_new = (32'(opa) & ~wmask) | (w_data & wmask);
  wire [31:0] opb_new = (32'(opb) & ~wmask) | (w_data & wmask);
  wire [31:0] cmd_new = w_data & wmask;
  wire [fpc_pkg::FLAG_COUNT-1:0] flag_clr =
    wr_flags ? w_data[fpc_pkg::FLAG_COUNT-1:0] & wmask[fpc_pkg::FLAG_COUNT-1:0] : '0;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= fpc_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (w_take) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? fpc_pkg::RESP_OKAY : fpc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_vector <= fpc_pkg::CTRL_RESET[fpc_pkg::CTRL_VECTOR_BIT];
      ctrl_mask <= fpc_pkg::CTRL_RESET[fpc_pkg::CTRL_MASK_BIT];
      opa <= '0;
      opb <= '0;
      cmd <= '0;
      go <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_vector <= ctrl_new[fpc_pkg::CTRL_VECTOR_BIT];
        ctrl_mask <= ctrl_new[fpc_pkg::CTRL_MASK_BIT];
      end
      if (wr_opa) begin
        opa <= opa_new[W-1:0];
      end
      if (wr_opb) begin
        opb <= opb_new[W-1:0];
      end
      if (wr_cmd) begin
        cmd <= cmd_new;
      end
      go <= wr_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Classification and NaN selection
  // ----------------------------------------------------------------
  wire fpc_pkg::fpc_op_e op = fpc_pkg::fpc_op_e'(cmd[fpc_pkg::CMD_OP_LSB +: 2]);
  wire unary = cmd[fpc_pkg::CMD_UNARY_BIT];
  wire inv_req = cmd[fpc_pkg::CMD_INVALID_BIT];
  wire fpc_pkg::fpc_class_e ca = classify(opa);
  wire fpc_pkg::fpc_class_e cb_raw = classify(opb);
  wire fpc_pkg::fpc_class_e cb = unary ? fpc_pkg::CL_ZERO : cb_raw;
  wire a_nan = is_nan(ca);
  wire b_nan = is_nan(cb);
  wire a_snan = (ca == fpc_pkg::CL_SNAN);
  wire b_snan = (cb == fpc_pkg::CL_SNAN);
  wire any_snan = (op != fpc_pkg::OP_PACK) && (a_snan || b_snan);
  wire any_denorm = (op != fpc_pkg::OP_PACK) &&
    ((ca == fpc_pkg::CL_DENORM) || (cb == fpc_pkg::CL_DENORM));
  wire a_larger = opa[FRAC_W-2:0] >= opb[FRAC_W-2:0];
  // Infinity alone never raises; only an explicit invalid request or a signaling source does.
  wire invalid = any_snan || ((op == fpc_pkg::OP_SELECT) && inv_req && !a_nan && !b_nan);
  wire trap = invalid && !ctrl_mask;

  logic [W-1:0] nan_pick;
  always_comb begin
    if (a_nan && b_nan) begin
      if (ctrl_vector) begin
        nan_pick = quiet(opa);
      end else if (a_snan != b_snan) begin
        nan_pick = a_snan ? opb : opa;
      end else begin
        nan_pick = quiet(a_larger ? opa : opb);
      end
    end else if (a_nan) begin
      nan_pick = quiet(opa);
    end else if (b_nan) begin
      nan_pick = quiet(opb);
    end else if (inv_req) begin
      nan_pick = fpc_pkg::QNAN_INDEFINITE[W-1:0];
    end else begin
      nan_pick = opa;
    end
  end

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  wire both_zero = (ca == fpc_pkg::CL_ZERO) && (cb_raw == fpc_pkg::CL_ZERO);
  wire [W-1:0] key_a = order_key(opa);
  wire [W-1:0] key_b = order_key(opb);
  logic [1:0] cmp_now;
  always_comb begin
    if (a_nan || is_nan(cb_raw)) begin
      cmp_now = fpc_pkg::CMP_UN;
    end else if (both_zero || key_a == key_b) begin
      cmp_now = fpc_pkg::CMP_EQ;
    end else if (key_a < key_b) begin
      cmp_now = fpc_pkg::CMP_LT;
    end else begin
      cmp_now = fpc_pkg::CMP_GT;
    end
  end

  // ----------------------------------------------------------------
  // Pack: normalize, denormalize and bias
  // ----------------------------------------------------------------
  wire signed [XW-1:0] pack_texp = cmd[fpc_pkg::CMD_TEXP_LSB +: XW];
  wire [SW-1:0] pack_sig = opb[SW-1:0];
  int lz;
  int pexp;
  int shamt;
  logic [SW-1:0] psig;
  logic [W-1:0] pack_res;
  logic pack_uf;
  always_comb begin
    lz = 0;
    for (int i = 0; i < SW; i++) begin
      if (pack_sig[i]) begin
        lz = SW - 1 - i;
      end
    end
    pexp = int'(pack_texp) - lz;
    psig = pack_sig << lz;
    shamt = fpc_pkg::EXP_MIN - pexp;
    pack_uf = 1'b0;
    if (pack_sig == '0) begin
      pack_res = {cmd[fpc_pkg::CMD_SIGN_BIT], {(W-1){1'b0}}};
    end else if (pexp > fpc_pkg::EXP_MAX) begin
      pack_res = {cmd[fpc_pkg::CMD_SIGN_BIT], {EXP_W{1'b1}}, {FRAC_W{1'b0}}};
    end else begin
      if (shamt > 0) begin
        psig = (shamt >= SW) ? '0 : psig >> shamt;
        pexp = fpc_pkg::EXP_MIN;
      end
      pack_uf = (psig != '0) && !psig[SW-1];
      pack_res = {cmd[fpc_pkg::CMD_SIGN_BIT],
        psig[SW-1] ? EXP_W'(pexp + fpc_pkg::EXP_BIAS) : {EXP_W{1'b0}},
        psig[SW-2:0]};
    end
  end

  // ----------------------------------------------------------------
  // Registered results and sticky flags
  // ----------------------------------------------------------------
  logic [W-1:0] next_result;
  always_comb begin
    unique case (op)
      fpc_pkg::OP_COMPARE: next_result = W'(cmp_now);
      fpc_pkg::OP_PACK: next_result = pack_res;
      default: next_result = nan_pick;
    endcase
  end

  wire [fpc_pkg::FLAG_COUNT-1:0] flag_set = go ?
    {trap, op == fpc_pkg::OP_PACK && pack_uf, any_denorm, invalid} : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= '0;
      class_a <= '0;
      class_b <= '0;
      cmp_code <= '0;
      written <= 1'b0;
      done <= 1'b0;
      result_valid <= 1'b0;
      invalid_trap <= 1'b0;
      flags <= '0;
    end else begin
      result_valid <= go;
      invalid_trap <= go && trap;
      if (wr_cmd) begin
        done <= 1'b0;
      end else if (go) begin
        done <= 1'b1;
      end
      if (go) begin
        class_a <= ca;
        class_b <= cb_raw;
        cmp_code <= cmp_now;
        written <= !trap;
        if (!trap) begin
          result <= next_result;
        end
      end
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  wire ar_take = s_axi_arvalid && !rvalid;
  wire [31:0] status_word = 32'({done, written, 2'b00, cmp_code, 1'b0, class_b, 1'b0, class_a});
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      fpc_pkg::ADDR_CTRL: rd_word = ctrl_word;
      fpc_pkg::ADDR_OPA: rd_word = 32'(opa);
      fpc_pkg::ADDR_OPB: rd_word = 32'(opb);
      fpc_pkg::ADDR_CMD: rd_word = cmd;
      fpc_pkg::ADDR_RESULT: rd_word = 32'(result);
      fpc_pkg::ADDR_STATUS: rd_word = status_word;
      fpc_pkg::ADDR_FLAGS: rd_word = 32'(flags);
      default: begin
        rd_word = '0;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= fpc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_ok ? fpc_pkg::RESP_OKAY : fpc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// ==== tb/fpc_classify_nan_assertions.sv ====
`timescale 1ns/1ps
module fpc_classify_nan_checker (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, low.
  input wire logic s_axi_awvalid, // AW valid.
  input wire logic s_axi_awready, // AW ready.
  input wire logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic [1:0] s_axi_bresp, // B code.
  input wire logic s_axi_bvalid, // B valid.
  input wire logic s_axi_bready, // B ready.
  input wire logic s_axi_arvalid, // AR valid.
  input wire logic s_axi_arready, // AR ready.
  input wire logic [31:0] s_axi_rdata, // R data.
  input wire logic s_axi_rvalid, // R valid.
  input wire logic s_axi_rready, // R ready.
  input wire logic result_valid, // Done pulse.
  input wire logic invalid_trap // Trap pulse.
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write response late");
  aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted");
  done_pulse_a: assert property (result_valid |=> !result_valid)
    else $error("done pulse too long");
  done_cause_a: assert property (result_valid |-> $past(s_axi_bvalid))
    else $error("done without a command write");
  trap_pulse_a: assert property ($rose(invalid_trap) |=> $fell(invalid_trap))
    else $error("trap pulse too long");
endmodule

bind fpc_classify_nan fpc_classify_nan_checker u_chk (.*);

// ==== tb/fpc_pipe_model.sv ====
`timescale 1ns/1ps
module fpc_pipe_model (
  input wire logic aclk, // Clock.
  output logic [7:0] s_axi_awaddr, // Write address.
  output logic s_axi_awvalid, // AW valid.
  input wire logic s_axi_awready, // AW ready.
  output logic [31:0] s_axi_wdata, // Write data.
  output logic s_axi_wvalid, // W valid.
  input wire logic s_axi_wready, // W ready.
  input wire logic [1:0] s_axi_bresp, // B code.
  input wire logic s_axi_bvalid, // B valid.
  output logic s_axi_bready, // B ready.
  output logic [7:0] s_axi_araddr, // Read address.
  output logic s_axi_arvalid, // AR valid.
  input wire logic s_axi_arready, // AR ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic [1:0] s_axi_rresp, // R code.
  input wire logic s_axi_rvalid, // R valid.
  output logic s_axi_rready // R ready.
);
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end

  // A late ready after lag cycles makes the slave hold its answer.
  task automatic write(input logic [7:0] ad, input logic [31:0] d, input int lag,
                       output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == lag) s_axi_bready <= 1'b1;
      n++;
    end while (!(s_axi_bvalid && s_axi_bready));
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    s_axi_awaddr <= ~ad;
    s_axi_wdata <= ~d;
  endtask

  task automatic read(input logic [7:0] ad, input int lag, output logic [31:0] d,
                      output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == lag) s_axi_rready <= 1'b1;
      n++;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    s_axi_araddr <= ~ad;
  endtask
endmodule

// ==== tb/fp_operand_classify_nan_propagate_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module fp_operand_classify_nan_propagate_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, result_valid, invalid_trap;
  int errors = 0;
  int tests_run = 0;
  int pulses = 0;
  logic trap_seen = 1'b0;
  logic [31:0] ca[5] = '{32'h0000_0000, 32'hFF80_0000, 32'h7F80_0000, 32'h7FC0_0001, 32'hBF80_0000};
  logic [31:0] cb[5] = '{32'h8000_0000, 32'h3F80_0000, 32'h7F7F_FFFF, 32'h3F80_0000, 32'hC000_0000};
  logic [31:0] cr[5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h2};
  logic [9:0] pe[6] = '{10'h000, 10'h001, 10'h360, 10'h382, 10'h080, 10'h37F};
  logic [23:0] ps[6] = '{24'h80_0000, 24'h40_0000, 24'h80_0000, 24'h80_0000, 24'h80_0000,
                         24'hAE_0000};
  logic [31:0] pr[6] = '{32'h3F80_0000, 32'hBF80_0000, 32'h0000_0000, 32'h0080_0000,
                         32'h7F80_0000, 32'h0015_C000};

  fpc_classify_nan u_dut (.*);
  fpc_pipe_model u_pm (.*);

  always #5 aclk = ~aclk;

  // The completion pulse can come and go while the bus task still waits for its response.
  always @(posedge aclk) begin
    if (result_valid) begin
      pulses <= pulses + 1;
      trap_seen <= invalid_trap;
    end
  end

  // --------------------------------------------------------------
  // Expectation helpers
  // --------------------------------------------------------------
  function automatic logic sn(input logic [31:0] x);
    return &x[30:23] && |x[22:0] && !x[22];
  endfunction
  function automatic logic dn(input logic [31:0] x);
    return x[30:23] == 8'h00 && |x[22:0];
  endfunction
  function automatic logic [2:0] cls(input logic [31:0] x);
    if (x[30:23] == 8'hFF) return x[22:0] == 0 ? 3'd3 : (x[22] ? 3'd4 : 3'd5);
    if (x[30:23] == 8'h00) return x[22:0] == 0 ? 3'd0 : 3'd1;
    return 3'd2;
  endfunction
  function automatic logic [31:0] sel(input logic [31:0] a, b, input logic v, u);
    logic na, nb;
    na = &a[30:23] && |a[22:0];
    nb = &b[30:23] && |b[22:0] && !u;
    if (!nb) return na ? a | 32'h0040_0000 : a;
    if (!na) return b | 32'h0040_0000;
    if (v) return a | 32'h0040_0000;
    if (a[22] != b[22]) return a[22] ? a : b;
    return (b[22:0] > a[22:0]) ? b | 32'h0040_0000 : a | 32'h0040_0000;
  endfunction
  function automatic logic [31:0] gen(input int unsigned k);
    logic [22:0] f;
    f = 23'($urandom) | 23'h1;
    case (k)
      0: return {1'($urandom), 8'hFF, 1'b1, f[21:0]};
      1: return {1'($urandom), 8'hFF, 1'b0, f[21:0]};
      2: return {1'($urandom), 8'($urandom_range(254, 1)), f};
      3: return {1'($urandom), 8'h00, f};
      4: return {1'($urandom), 31'h0};
      default: return {1'($urandom), 8'hFF, 23'h0};
    endcase
  endfunction

  // --------------------------------------------------------------
  // Bus and command tasks
  // --------------------------------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [1:0] rs;
    u_pm.write(ad, d, $urandom_range(2), rs);
    `CHK(rs, fpc_pkg::RESP_OKAY)
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] rs;
    u_pm.read(ad, $urandom_range(2), d, rs);
    `CHK(rs, fpc_pkg::RESP_OKAY)
    `CHK(d & m, e)
  endtask
  // Exactly one completion pulse must follow each command write.
  task automatic run_cmd(input logic [31:0] a, b, c, input logic trap);
    int seen;
    wr(fpc_pkg::ADDR_OPA, a);
    wr(fpc_pkg::ADDR_OPB, b);
    seen = pulses;
    wr(fpc_pkg::ADDR_CMD, c);
    repeat (2) @(posedge aclk);
    `CHK(pulses - seen, 1)
    `CHK(trap_seen, trap)
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    end_sim();
  end

  initial begin
    logic [31:0] a, b, d, last;
    logic un;
    logic [1:0] rs;
    void'($urandom(32'h61d7));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(fpc_pkg::ADDR_CTRL, fpc_pkg::CTRL_RESET, '1);
    u_pm.read(8'h1C, 0, d, rs);
    `CHK(rs, fpc_pkg::RESP_SLVERR)
    `CHK(d, 32'h0000_0000)
    u_pm.write(8'h1C, 32'h0000_0000, 0, rs);
    `CHK(rs, fpc_pkg::RESP_SLVERR)
    for (int i = 0; i < 40; i++) begin
      a = gen($urandom_range(5));
      b = gen($urandom_range(5));
      un = ($urandom_range(3) == 0);
      last = sel(a, b, i[0], un);
      wr(fpc_pkg::ADDR_CTRL, {30'h0, 1'b1, i[0]});
      run_cmd(a, b, {29'h0, un, 2'b00}, 1'b0);
      rd_chk(fpc_pkg::ADDR_RESULT, last, '1);
      rd_chk(fpc_pkg::ADDR_STATUS, {18'h0, 2'b11, 5'h0, cls(b), 1'b0, cls(a)},
             32'h0000_3077);
      rd_chk(fpc_pkg::ADDR_FLAGS, {30'h0, dn(a) | (!un && dn(b)), sn(a) | (!un && sn(b))},
             32'h0000_0003);
      wr(fpc_pkg::ADDR_FLAGS, 32'h0000_000F);
    end
    wr(fpc_pkg::ADDR_CTRL, 32'h0000_0000);
    run_cmd(gen(1), 32'h3F80_0000, 32'h0, 1'b1);
    rd_chk(fpc_pkg::ADDR_RESULT, last, '1);
    rd_chk(fpc_pkg::ADDR_STATUS, 32'h0, 32'h0000_1000);
    rd_chk(fpc_pkg::ADDR_FLAGS, 32'h0000_0009, 32'h0000_0009);
    a = gen(0);
    run_cmd(a, 32'h3F80_0000, 32'h0, 1'b0);
    rd_chk(fpc_pkg::ADDR_RESULT, a, '1);
    wr(fpc_pkg::ADDR_CTRL, 32'h0000_0002);
    run_cmd(32'h3F80_0000, 32'h4000_0000, 32'h0000_0008, 1'b0);
    rd_chk(fpc_pkg::ADDR_RESULT, fpc_pkg::QNAN_INDEFINITE, '1);
    for (int k = 0; k < 5; k++) begin
      run_cmd(ca[k], cb[k], 32'h0000_0001, 1'b0);
      rd_chk(fpc_pkg::ADDR_RESULT, cr[k], '1);
      rd_chk(fpc_pkg::ADDR_STATUS, {22'h0, cr[k][1:0], 8'h0}, 32'h0000_0300);
    end
    wr(fpc_pkg::ADDR_FLAGS, 32'h0000_000F);
    for (int k = 0; k < 6; k++) begin
      run_cmd(32'h0, {8'h00, ps[k]}, {6'h0, pe[k], 11'h0, k == 1, 4'b0010}, 1'b0);
      rd_chk(fpc_pkg::ADDR_RESULT, pr[k], '1);
    end
    rd_chk(fpc_pkg::ADDR_FLAGS, 32'h0000_0004, 32'h0000_0004);
    end_sim();
  end
endmodule
